//--- core/fault_irq_pkg.sv
/*
 Shared constants and types for the fault interrupt-enable bank.
 Assumes 16-bit enable registers and 17-bit status and mask registers on a 32-bit classic Wishbone bus.
*/
package fault_irq_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0] idx_supply_en = 8'h08;
   localparam logic [7:0] idx_boost_en = 8'h0a;
   localparam logic [7:0] idx_string_en = 8'h0c;
   localparam logic [7:0] idx_fault_status = 8'h10;
   localparam logic [7:0] idx_fault_mask = 8'h11;
   localparam logic [9:0] addr_supply_en = 10'h020;
   localparam logic [9:0] addr_boost_en = 10'h028;
   localparam logic [9:0] addr_string_en = 10'h030;
   localparam logic [9:0] addr_fault_status = 10'h040;
   localparam logic [9:0] addr_fault_mask = 10'h044;
   // Reset values
   localparam logic [15:0] rst_supply_en = 16'h2aaa;
   localparam logic [15:0] rst_boost_en = 16'ha028;
   localparam logic [15:0] rst_string_en = 16'h00aa;
   localparam logic [15:0] rst_fault_mask = 16'h0000;
   // Keyed write codes and read values
   localparam logic [1:0] code_disable = 2'h1;
   localparam logic [1:0] code_enable = 2'h3;
   localparam logic [1:0] read_enabled = 2'h2;
   localparam logic [1:0] read_disabled = 2'h0;
   // Field counts per register
   localparam int supply_fields = 7;
   localparam int boost_fields = 7;
   localparam int string_fields = 4;
   // Field base bit positions
   localparam int pos_sync_loss = 12;
   localparam int pos_pump_fault = 10;
   localparam int pos_pump_cap = 8;
   localparam int pos_input_ocp = 6;
   localparam int pos_core_uv = 4;
   localparam int pos_input_ovp = 2;
   localparam int pos_input_uv = 0;
   localparam int pos_thermal = 14;
   localparam int pos_current_set_short = 12;
   localparam int pos_string_set = 10;
   localparam int pos_mode_set = 8;
   localparam int pos_freq_set = 6;
   localparam int pos_conv_ocp = 4;
   localparam int pos_conv_ovp = 2;
   localparam int pos_global = 6;
   localparam int pos_bus_timeout = 4;
   localparam int pos_bad_string = 2;
   localparam int pos_led_fault = 0;
   // Number of fault sources
   localparam int fault_count = 17;

   // Wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [9:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   // Wishbone answer bundle
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;
endpackage

//--- core/keyed_enable_field.sv
/*
 One two-bit keyed interrupt-enable field.
 Assumes the parent supplies a one-cycle write strobe with the field code.
*/
`timescale 1ns/1ps
module keyed_enable_field #(
   parameter logic reset_on = 1'b1
) (
   input wire logic clock,             // System clock
   input wire logic rst_n,             // Synchronised reset, active low
   input wire logic ce,                // Clock enable
   input wire logic write_strobe,      // Field written this cycle
   input wire logic [1:0] write_code,  // Written two-bit code
   output logic enabled,               // Current state
   output logic [1:0] read_value       // Value seen on a read
);
   import fault_irq_pkg::*;

   wire logic do_enable;
   wire logic do_disable;

   assign do_enable = write_strobe && (write_code == code_enable);
   assign do_disable = write_strobe && (write_code == code_disable);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enabled <= reset_on;
      end else if (ce && do_enable) begin
         enabled <= 1'b1;
      end else if (ce && do_disable) begin
         enabled <= 1'b0;
      end
   end

   assign read_value = enabled ? read_enabled : read_disabled;
endmodule

//--- core/fault_interrupt_enable_bank.sv
/*
 Fault interrupt-enable bank with sticky fault status and an irq line.
 Assumes a classic Wishbone master on the same clock and fault inputs
 from detectors in other clock domains or pins.
*/
`timescale 1ns/1ps
module fault_interrupt_enable_bank (
   input wire logic clock,                    // 200 MHz system clock
   input wire logic rst_n,                    // Async reset, active low
   input wire logic ce,                       // Clock enable
   input wire fault_irq_pkg::wb_req_t wb_req, // Wishbone request
   output fault_irq_pkg::wb_rsp_t wb_rsp,     // Wishbone answer
   input wire logic [16:0] fault_in,          // Raw fault levels
   output logic [16:0] fault_gated,           // Faults passing enables
   output logic irq                           // Level interrupt
);
   import fault_irq_pkg::*;

   logic rst_meta;
   logic rst_sync_n;
   logic [fault_count-1:0] sync_a;
   logic [fault_count-1:0] sync_b;
   logic [fault_count-1:0] sync_c;
   logic [fault_count-1:0] fault_level;
   logic [fault_count-1:0] fault_status;
   logic [fault_count-1:0] fault_mask;
   logic ack;
   logic [31:0] rdata;

   wire logic bus_req;
   wire logic bus_wr;
   wire logic hit_supply;
   wire logic hit_boost;
   wire logic hit_string;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic wr_lo;
   wire logic wr_hi;
   wire logic [15:0] wdata;
   wire logic [supply_fields-1:0] supply_on;
   wire logic [boost_fields-1:0] boost_on;
   wire logic [string_fields-1:0] string_on;
   wire logic [15:0] supply_rd;
   wire logic [15:0] boost_rd;
   wire logic [15:0] string_rd;
   wire logic [fault_count-1:0] own_enable;
   wire logic global_on;
   wire logic [fault_count-1:0] fault_rise;
   wire logic [fault_count-1:0] clear_bits;
   wire logic [fault_count-1:0] next_status;
   wire logic [fault_count-1:0] next_gated;
   wire logic [31:0] next_rdata;
   wire logic next_irq;

   // Reset release through two flip-flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Bus decode
   assign bus_req = wb_req.cyc && wb_req.stb && !ack;
   assign bus_wr = bus_req && wb_req.we && ce;
   assign hit_supply = (wb_req.adr == addr_supply_en);
   assign hit_boost = (wb_req.adr == addr_boost_en);
   assign hit_string = (wb_req.adr == addr_string_en);
   assign hit_status = (wb_req.adr == addr_fault_status);
   assign hit_mask = (wb_req.adr == addr_fault_mask);
   assign wr_lo = bus_wr && wb_req.sel[0];
   assign wr_hi = bus_wr && wb_req.sel[1];
   assign wdata = wb_req.dat[15:0];

   keyed_enable_field #(.reset_on(1'b1)) u_sync_loss (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_supply),
      .write_code(wdata[pos_sync_loss +: 2]),
      .enabled(supply_on[6]),
      .read_value(supply_rd[pos_sync_loss +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_pump_fault (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_supply),
      .write_code(wdata[pos_pump_fault +: 2]),
      .enabled(supply_on[5]),
      .read_value(supply_rd[pos_pump_fault +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_pump_cap (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_supply),
      .write_code(wdata[pos_pump_cap +: 2]),
      .enabled(supply_on[4]),
      .read_value(supply_rd[pos_pump_cap +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_input_ocp (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_supply),
      .write_code(wdata[pos_input_ocp +: 2]),
      .enabled(supply_on[3]),
      .read_value(supply_rd[pos_input_ocp +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_core_uv (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_supply),
      .write_code(wdata[pos_core_uv +: 2]),
      .enabled(supply_on[2]),
      .read_value(supply_rd[pos_core_uv +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_input_ovp (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_supply),
      .write_code(wdata[pos_input_ovp +: 2]),
      .enabled(supply_on[1]),
      .read_value(supply_rd[pos_input_ovp +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_input_uv (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_supply),
      .write_code(wdata[pos_input_uv +: 2]),
      .enabled(supply_on[0]),
      .read_value(supply_rd[pos_input_uv +: 2])
   );
   assign supply_rd[15:14] = 2'h0;

   keyed_enable_field #(.reset_on(1'b1)) u_thermal (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_boost),
      .write_code(wdata[pos_thermal +: 2]),
      .enabled(boost_on[6]),
      .read_value(boost_rd[pos_thermal +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_current_short (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_boost),
      .write_code(wdata[pos_current_set_short +: 2]),
      .enabled(boost_on[5]),
      .read_value(boost_rd[pos_current_set_short +: 2])
   );
   keyed_enable_field #(.reset_on(1'b0)) u_string_set (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_boost),
      .write_code(wdata[pos_string_set +: 2]),
      .enabled(boost_on[4]),
      .read_value(boost_rd[pos_string_set +: 2])
   );
   keyed_enable_field #(.reset_on(1'b0)) u_mode_set (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_hi && hit_boost),
      .write_code(wdata[pos_mode_set +: 2]),
      .enabled(boost_on[3]),
      .read_value(boost_rd[pos_mode_set +: 2])
   );
   keyed_enable_field #(.reset_on(1'b0)) u_freq_set (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_boost),
      .write_code(wdata[pos_freq_set +: 2]),
      .enabled(boost_on[2]),
      .read_value(boost_rd[pos_freq_set +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_conv_ocp (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_boost),
      .write_code(wdata[pos_conv_ocp +: 2]),
      .enabled(boost_on[1]),
      .read_value(boost_rd[pos_conv_ocp +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_conv_ovp (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_boost),
      .write_code(wdata[pos_conv_ovp +: 2]),
      .enabled(boost_on[0]),
      .read_value(boost_rd[pos_conv_ovp +: 2])
   );
   assign boost_rd[1:0] = 2'h0;

   keyed_enable_field #(.reset_on(1'b1)) u_global (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_string),
      .write_code(wdata[pos_global +: 2]),
      .enabled(string_on[3]),
      .read_value(string_rd[pos_global +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_bus_timeout (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_string),
      .write_code(wdata[pos_bus_timeout +: 2]),
      .enabled(string_on[2]),
      .read_value(string_rd[pos_bus_timeout +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_bad_string (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_string),
      .write_code(wdata[pos_bad_string +: 2]),
      .enabled(string_on[1]),
      .read_value(string_rd[pos_bad_string +: 2])
   );
   keyed_enable_field #(.reset_on(1'b1)) u_led_fault (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ce(ce),
      .write_strobe(wr_lo && hit_string),
      .write_code(wdata[pos_led_fault +: 2]),
      .enabled(string_on[0]),
      .read_value(string_rd[pos_led_fault +: 2])
   );
   // Upper byte of the string register is unused
   assign string_rd[15:8] = 8'h00;

   // Pin faults pass three flip-flops; b and c must agree
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
         fault_level <= '0;
      end else if (ce) begin
         sync_a <= fault_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
         fault_level <= (sync_b & sync_c) | (fault_level & (sync_b | sync_c));
      end
   end

   // Per-source enable; global field is bit 3 of string_on
   assign global_on = string_on[3];
   assign own_enable = {supply_on, boost_on, string_on[2:0]};

   assign next_gated = fault_level & own_enable & {fault_count{global_on}};

   // Sticky status: rising gated fault sets, write-one clears, set wins
   assign fault_rise = next_gated & ~fault_gated;
   assign clear_bits = (bus_wr && hit_status) ?
                       (wb_req.dat[fault_count-1:0] &
                        {{fault_count-16{wb_req.sel[2]}},
                         {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}}) : '0;
   assign next_status = (fault_status & ~clear_bits) | fault_rise;
   assign next_irq = |(next_status & fault_mask);

   // Read mux
   assign next_rdata = hit_supply ? {16'h0000, supply_rd} :
                       hit_boost ? {16'h0000, boost_rd} :
                       hit_string ? {16'h0000, string_rd} :
                       hit_status ? {15'h0000, fault_status} :
                       hit_mask ? {15'h0000, fault_mask} : 32'h0000_0000;

   // Status, mask and outputs
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fault_status <= '0;
         fault_mask <= {1'b0, rst_fault_mask};
         fault_gated <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         fault_status <= next_status;
         if (bus_wr && hit_mask) begin
            fault_mask <= wb_req.dat[fault_count-1:0];
         end
         fault_gated <= next_gated;
         irq <= next_irq;
      end
   end

   // Single-cycle ack; unmapped reads return zero
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         ack <= bus_req;
         rdata <= bus_req ? next_rdata : 32'h0000_0000;
      end
   end

   // Answer bundle straight from flip-flops
   assign wb_rsp.ack = ack;
   assign wb_rsp.dat = rdata;
endmodule

//--- sim/fault_bank_monitor.sv
/*
 Port checker for the fault interrupt-enable bank.
 Assumes one clock and the bank's one-cycle ack.
*/
`timescale 1ns/1ps
module fault_bank_monitor (
   input wire logic clock,                    // System clock
   input wire logic rst_n,                    // Reset, active low
   input wire logic ce,                       // Clock enable
   input wire fault_irq_pkg::wb_req_t wb_req, // Bus request
   input wire fault_irq_pkg::wb_rsp_t wb_rsp, // Bus answer
   input wire logic [16:0] fault_in,          // Raw faults
   input wire logic [16:0] fault_gated,       // Gated faults
   input wire logic irq                       // Interrupt
);
   import fault_irq_pkg::*;
   logic [3:0] quiet;
   logic rd;
   logic mapped;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Read request decode
   assign rd = wb_req.cyc && wb_req.stb && !wb_req.we && !wb_rsp.ack && ce;
   assign mapped = wb_req.adr inside {addr_supply_en, addr_boost_en,
      addr_string_en, addr_fault_status, addr_fault_mask};
   // Cycles since any raw fault was seen
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) quiet <= 4'h0;
      else if (fault_in != 17'h0) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   sequence s_take;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack && ce;
   endsequence
   sequence s_read(logic [9:0] a);
      rd && wb_req.adr == a;
   endsequence
   a_ack_after_take: assert property (s_take |=> wb_rsp.ack)
      else $error("No ack one cycle after a request");
   a_ack_single_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("Ack held longer than one cycle");
   a_idle_dat_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 0)
      else $error("Read data not zero outside ack");
   a_supply_read_codes: assert property (s_read(addr_supply_en) |=>
      (wb_rsp.dat & 32'hffffd555) == 32'h0)
      else $error("Supply enables read an illegal code");
   a_boost_read_codes: assert property (s_read(addr_boost_en) |=>
      (wb_rsp.dat & 32'hffff5557) == 32'h0)
      else $error("Boost enables read an illegal code");
   a_string_read_codes: assert property (s_read(addr_string_en) |=>
      (wb_rsp.dat & 32'hffffff55) == 32'h0)
      else $error("String enables read an illegal code");
   a_unmapped_read_zero: assert property (rd && !mapped |=>
      wb_rsp.ack && wb_rsp.dat == 32'h0)
      else $error("Unmapped read returned data");
   a_quiet_no_gate: assert property (quiet >= 4'h8 |->
      fault_gated == 17'h0)
      else $error("Gated fault without a raw fault");
   a_irq_has_cause: assert property ($rose(irq) |->
      fault_gated != $past(fault_gated) || $past(wb_rsp.ack))
      else $error("Interrupt rose with no fault or bus write");
endmodule
bind fault_interrupt_enable_bank fault_bank_monitor mon (.clock(clock),
   .rst_n(rst_n), .ce(ce), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .fault_in(fault_in), .fault_gated(fault_gated), .irq(irq));

//--- sim/fault_interrupt_enable_bank_bench.sv
/*
 Register and fault tests for the fault interrupt-enable bank.
 Assumes the checker is bound to the bank.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
   mismatches++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module fault_interrupt_enable_bank_bench;
   import fault_irq_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   wb_req_t req = '0;
   wb_rsp_t rsp;
   logic [16:0] fin = 17'h0;
   logic [16:0] fg;
   logic irq;
   logic ce_in = 1'b1;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] q;
   logic [15:0] e;
   logic [9:0] ra [3] = '{addr_supply_en, addr_boost_en, addr_string_en};
   logic [15:0] rv [3] = '{16'h2aaa, 16'ha028, 16'h00aa};
   logic [15:0] vm [3] = '{16'h2aaa, 16'haaa8, 16'h00aa};
   fault_interrupt_enable_bank dut (.clock(clock), .rst_n(rst_n),
      .ce(ce_in), .wb_req(req), .wb_rsp(rsp), .fault_in(fin),
      .fault_gated(fg), .irq(irq));
   initial forever #2.5 clock = ~clock;
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One classic cycle, held until ack is sampled
   task automatic bus(input logic [9:0] a, input logic w,
         input logic [3:0] s, input logic [31:0] d);
      @(posedge clock);
      req <= '{1'b1, 1'b1, w, s, a, d};
      do @(posedge clock); while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      bus(a, 1'b1, 4'h7, d);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] x);
      bus(a, 1'b0, 4'hf, 32'h0);
      `CHK(q, x)
   endtask
   task automatic settle();
      repeat (8) @(posedge clock);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(addr_supply_en, 32'h2aaa);
      rd(addr_boost_en, 32'ha028);
      rd(addr_string_en, 32'h00aa);
      wr(10'h3fc, 32'hffff);
      rd(10'h3fc, 32'h0);
      wr(addr_fault_mask, 32'h1ffff);
      fin <= 17'h00200;
      settle();
      `CHK(fg, 17'h00200)
      `CHK(irq, 1'b1)
      rd(addr_fault_status, 32'h200);
      wr(addr_fault_mask, 32'h0);
      settle();
      `CHK(irq, 1'b0)
      wr(addr_fault_mask, 32'h1ffff);
      fin <= 17'h0;
      wr(addr_fault_status, 32'h200);
      settle();
      `CHK(irq, 1'b0)
      rd(addr_fault_status, 32'h0);
      fin <= 17'h00080;
      settle();
      `CHK(fg, 17'h0)
      rd(addr_fault_status, 32'h0);
      wr(addr_string_en, 32'h40);
      fin <= 17'h00200;
      settle();
      `CHK(fg, 17'h0)
      `CHK(irq, 1'b0)
      rd(addr_string_en, 32'h2a);
      // Enabling with a fault already present raises it
      wr(addr_string_en, 32'hc0);
      settle();
      `CHK(fg, 17'h00200)
      `CHK(irq, 1'b1)
      fin <= 17'h0;
      wr(addr_fault_status, 32'h200);
      // Walk every field: disable, no-change code, enable
      for (int r = 0; r < 3; r++) begin
         e = rv[r];
         for (int f = 0; f < 8; f++) begin
            wr(ra[r], 32'(16'h1 << (2 * f)));
            e = e & ~(16'h2 << (2 * f));
            rd(ra[r], {16'h0, e});
            wr(ra[r], 32'(16'h2 << (2 * f)));
            rd(ra[r], {16'h0, e});
            wr(ra[r], 32'(16'h3 << (2 * f)));
            e = e | ((16'h2 << (2 * f)) & vm[r]);
            rd(ra[r], {16'h0, e});
         end
      end
      // Clock enable low freezes the fault path
      ce_in <= 1'b0;
      fin <= 17'h10000;
      settle();
      `CHK(fg, 17'h0)
      `CHK(irq, 1'b0)
      ce_in <= 1'b1;
      settle();
      `CHK(fg, 17'h10000)
      `CHK(irq, 1'b1)
      rd(addr_fault_status, 32'h10000);
      fin <= 17'h0;
      bus(addr_supply_en, 1'b1, 4'h1, 32'h5555);
      rd(addr_supply_en, 32'h2a00);
      tally_and_finish();
   end
endmodule
